// ==== hw/aci_map.svh ====
// Purpose: constants for the conversion interface
// Assumes: 250 MHz clock
// Notes: counts derived from times in ns
`ifndef ACI_MAP_SVH
`define ACI_MAP_SVH
`define ACI_CLK_NS 4
`define ACI_CONV_NS 740
`define ACI_CONV_CYC ((`ACI_CONV_NS + `ACI_CLK_NS - 1) / `ACI_CLK_NS)
`define ACI_RES_W 12
`define ACI_FIFO_DEPTH 16
`define ACI_FIFO_AW 4
`define ACI_EST_W 2
`define ACI_FL1_W 4
`define ACI_FL2_W 4
`define ACI_FL3_W 2
`define ACI_CNT_W 8
`define ACI_CNT_ONE 8'h01
`endif

// ==== hw/aci_pkg.sv ====
// Purpose: types for the conversion interface
// Assumes: aci_map.svh constants
// Notes: none
`include "aci_map.svh"
package aci_pkg;
  typedef enum logic [1:0] {
    ACI_TRACK = 2'b00,
    ACI_CONV = 2'b01,
    ACI_DONE = 2'b11
  } aci_state_t;
  typedef logic [`ACI_RES_W-1:0] aci_word_t;
endpackage : aci_pkg

// ==== hw/aci_stream_if.sv ====
// Purpose: valid/ready word stream between core and fifo
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
`include "aci_map.svh"
interface aci_stream_if;
  logic valid;
  logic ready;
  logic [`ACI_RES_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : aci_stream_if
`default_nettype wire

// ==== hw/aci_fifo.sv ====
// Purpose: result fifo, flip-flop storage
// Assumes: depth is a power of two
// Notes: full and empty from count
`timescale 1ns/1ps
`default_nettype none
module aci_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  aci_stream_if.snk s_in,
  aci_stream_if.src s_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign s_in.ready = (cnt_q != DEPTH[AW:0]);
  assign s_out.valid = (cnt_q != '0);
  assign s_out.data = mem_q[rd_q];
  assign push = s_in.valid && s_in.ready;
  assign pop = s_out.valid && s_out.ready;
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = s_in.data;
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end
endmodule : aci_fifo
`default_nettype wire

// ==== hw/aci_core.sv ====
// Purpose: control and read interface of a 12-bit sampling converter
// Assumes: strobes and selects arrive from pins; quantiser codes are stable
// Notes: conversion time is counted on i_clk
`timescale 1ns/1ps
`default_nettype none
`include "aci_map.svh"
module aci_core (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_sample_hold,
  input wire logic i_chip_sel_b,
  input wire logic i_read_b,
  input wire logic i_high_speed,
  input wire logic i_channel_select,
  input wire logic [`ACI_EST_W-1:0] i_est_code,
  input wire logic [`ACI_FL1_W-1:0] i_flash1_code,
  input wire logic [`ACI_FL2_W-1:0] i_flash2_code,
  input wire logic [`ACI_FL3_W-1:0] i_flash3_code,
  output logic o_conv_end,
  output logic o_done_int_b,
  output logic o_track_switch,
  output logic o_route_input_two,
  output logic [`ACI_RES_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_overrun
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] pin_raw, s1_q, s2_q, s3_q;
  assign pin_raw = {i_channel_select, i_read_b, i_chip_sel_b, i_sample_hold};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          s1_q[g] <= 1'b1;
          s2_q[g] <= 1'b1;
          s3_q[g] <= 1'b1;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end
    end
  endgenerate

  function automatic logic fell(input logic prev, input logic now);
    fell = prev && !now;
  endfunction

  logic cs_on, sh_fall, rd_fall;
  assign cs_on = !s2_q[1];
  assign sh_fall = cs_on && fell(s3_q[0], s2_q[0]);
  assign rd_fall = cs_on && fell(s3_q[2], s2_q[2]);

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  aci_pkg::aci_state_t st_q, st_d;
  logic [`ACI_CNT_W-1:0] cnt_q, cnt_d;
  logic [`ACI_RES_W-1:0] res_q, res_d;
  logic end_q, end_d;
  logic int_b_q, int_b_d;
  logic trk_q, trk_d;
  logic chan_q, chan_d;
  logic oe_q, oe_d;
  logic [`ACI_RES_W-1:0] dat_q, dat_d;
  logic ovr_q, ovr_d;
  aci_stream_if res_in ();
  aci_stream_if res_out ();

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    res_d = res_q;
    end_d = end_q;
    int_b_d = int_b_q;
    trk_d = trk_q;
    chan_d = chan_q;
    ovr_d = ovr_q;
    res_in.valid = 1'b0;
    unique case (st_q)
      aci_pkg::ACI_TRACK: begin
        trk_d = 1'b1;
        if (sh_fall) begin
          trk_d = 1'b0;
          st_d = aci_pkg::ACI_CONV;
          cnt_d = `ACI_CNT_ONE;
        end
      end
      aci_pkg::ACI_CONV: begin
        cnt_d = cnt_q + `ACI_CNT_ONE;
        if (cnt_q == `ACI_CNT_W'(`ACI_CONV_CYC)) begin
          res_d = {i_est_code, i_flash1_code, i_flash2_code, i_flash3_code};
          end_d = 1'b1;
          int_b_d = 1'b0;
          st_d = aci_pkg::ACI_DONE;
          res_in.valid = 1'b1;
          ovr_d = !res_in.ready;
        end
      end
      aci_pkg::ACI_DONE: begin
        trk_d = 1'b1;
        if (sh_fall) begin
          // end flag falls at the next hold edge; select is caught here
          end_d = 1'b0;
          chan_d = s2_q[3];
          trk_d = 1'b0;
          st_d = aci_pkg::ACI_CONV;
          cnt_d = `ACI_CNT_ONE;
        end
      end
      default: begin
        st_d = aci_pkg::ACI_TRACK;
      end
    endcase
    if (rd_fall && !i_high_speed) begin
      int_b_d = 1'b1;
    end
    if (st_q == aci_pkg::ACI_CONV && st_d == aci_pkg::ACI_DONE) begin
      int_b_d = 1'b0; // new completion wins over a read in the same cycle
    end
  end
  assign res_in.data = {i_est_code, i_flash1_code, i_flash2_code, i_flash3_code};

  // ************************************************************
  // result buffer and data bus
  // ************************************************************
  aci_fifo #(
    .WIDTH(`ACI_RES_W),
    .DEPTH(`ACI_FIFO_DEPTH),
    .AW(`ACI_FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .s_in(res_in.snk),
    .s_out(res_out.src)
  );

  // high speed drains every word so the bus shows the newest; interrupt mode pops on read
  assign res_out.ready = i_high_speed ? 1'b1 : rd_fall;

  always_comb begin
    dat_d = dat_q;
    oe_d = 1'b0;
    if (res_out.valid && res_out.ready) begin
      dat_d = res_out.data;
    end
    if (i_high_speed) begin
      oe_d = cs_on && !s2_q[2];
    end else begin
      oe_d = cs_on && !s2_q[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q <= aci_pkg::ACI_TRACK;
      cnt_q <= '0;
      res_q <= '0;
      end_q <= 1'b0;
      int_b_q <= 1'b1;
      trk_q <= 1'b1;
      chan_q <= 1'b0;
      ovr_q <= 1'b0;
      dat_q <= '0;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      end_q <= end_d;
      int_b_q <= int_b_d;
      trk_q <= trk_d;
      chan_q <= chan_d;
      ovr_q <= ovr_d;
      dat_q <= dat_d;
      oe_q <= oe_d;
    end
  end

  assign o_conv_end = end_q;
  assign o_done_int_b = int_b_q;
  assign o_track_switch = trk_q;
  assign o_route_input_two = chan_q;
  assign o_data = dat_q;
  assign o_data_oe = oe_q;
  assign o_overrun = ovr_q;
endmodule : aci_core
`default_nettype wire

// ==== tb/aci_core_chk.sv ====
// Purpose: port checks for aci_core
// Assumes: pins pass 2-3 sync stages
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module aci_core_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_chip_sel_b,
  input wire logic i_read_b,
  input wire logic o_conv_end,
  input wire logic o_done_int_b,
  input wire logic o_track_switch,
  input wire logic o_route_input_two,
  input wire logic o_data_oe
);
  // ****
  // checks
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  AST_END_INT: assert property ($rose(o_conv_end) |-> !o_done_int_b)
    else $error("done flag without interrupt");
  AST_CONV_TIME: assert property ($fell(o_track_switch) |-> ##[180:192] $rose(o_conv_end))
    else $error("conversion end late");
  AST_NO_EARLY: assert property ($fell(o_track_switch) |-> !o_conv_end [*8])
    else $error("end flag during hold");
  AST_INT_CLEAR: assert property ($rose(o_done_int_b) |->
    !$past(i_read_b, 2) || !$past(i_read_b, 3) || !$past(i_read_b, 4) || !$past(i_read_b, 5))
    else $error("interrupt cleared without read");
  AST_CS_GATE: assert property (i_chip_sel_b [*6] |-> !$fell(o_track_switch))
    else $error("hold taken without select");
  AST_ROUTE: assert property ($changed(o_route_input_two) |->
    !o_conv_end && ($past(o_conv_end) || $past(o_conv_end, 2)))
    else $error("route moved off end fall");
  AST_OE_ON: assert property ((!i_chip_sel_b && !i_read_b) [*5] |-> o_data_oe)
    else $error("drivers off");
  AST_OE_OFF: assert property ((i_chip_sel_b || i_read_b) [*5] |-> !o_data_oe)
    else $error("drivers on");
endmodule : aci_core_chk
`default_nettype wire

// ==== tb/aci_host_model.sv ====
// Purpose: host strobes for the conversion interface
// Assumes: tasks run from the bench
// Notes: strobes last 8 clocks for the sync stages
`timescale 1ns/1ps
`default_nettype none
module aci_host_model (
  input wire logic i_clk,
  output logic o_sample_hold,
  output logic o_chip_sel_b,
  output logic o_read_b
);
  // ****
  // strobes
  // ****
  initial begin
    o_sample_hold = 1'b1;
    o_chip_sel_b = 1'b1;
    o_read_b = 1'b1;
  end
  task automatic convert(input logic cs_b);
    @(negedge i_clk);
    o_chip_sel_b = cs_b;
    repeat (8) @(negedge i_clk);
    o_sample_hold = 1'b0;
    repeat (8) @(negedge i_clk);
    o_sample_hold = 1'b1;
    repeat (3) @(negedge i_clk);
  endtask : convert
  // keep leaves read low for high-speed use
  task automatic read(input logic keep);
    @(negedge i_clk);
    o_chip_sel_b = 1'b0;
    o_read_b = 1'b0;
    repeat (8) @(negedge i_clk);
    o_read_b = !keep;
    repeat (3) @(negedge i_clk);
  endtask : read
endmodule : aci_host_model
`default_nettype wire

// ==== tb/tb_aci_core.sv ====
// Purpose: bench for aci_core
// Assumes: host model drives the pins
// Notes: word is the codes concatenated
`timescale 1ns/1ps
`default_nettype none
`include "aci_map.svh"
module tb_aci_core;
  logic i_clk, i_rst_b, i_high_speed, i_channel_select, sh, cs_b, rd_b;
  logic o_conv_end, o_done_int_b, o_track_switch, o_route_input_two, o_data_oe, o_overrun;
  logic [`ACI_RES_W-1:0] code, o_data;
  int bad_count, total_checks, cycles;
  aci_host_model host (.i_clk(i_clk), .o_sample_hold(sh), .o_chip_sel_b(cs_b), .o_read_b(rd_b));
  aci_core dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sample_hold(sh), .i_chip_sel_b(cs_b),
    .i_read_b(rd_b), .i_high_speed(i_high_speed), .i_channel_select(i_channel_select),
    .i_est_code(code[11:10]), .i_flash1_code(code[9:6]), .i_flash2_code(code[5:2]),
    .i_flash3_code(code[1:0]), .o_conv_end(o_conv_end), .o_done_int_b(o_done_int_b),
    .o_track_switch(o_track_switch), .o_route_input_two(o_route_input_two),
    .o_data(o_data), .o_data_oe(o_data_oe), .o_overrun(o_overrun));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [`ACI_RES_W-1:0] got, input logic [`ACI_RES_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_end();
    int n;
    n = 0;
    while (o_conv_end !== 1'b1 && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    chk(o_conv_end, 1'b1);
  endtask : wait_end
  task automatic t_fill();
    for (int k = 0; k < 17; k++) begin
      code = 12'h5a0 + k[11:0];
      i_channel_select = k[0];
      host.convert(1'b0);
      chk(o_route_input_two, k[0]);
      wait_end();
      chk(o_done_int_b, 1'b0);
    end
    chk(o_overrun, 1'b1);
    host.read(1'b0);
    chk(o_data, 12'h5a0);
    chk(o_done_int_b, 1'b1);
    host.read(1'b0);
    chk(o_data, 12'h5a1);
  endtask : t_fill
  task automatic t_cs();
    host.convert(1'b1);
    repeat (200) @(negedge i_clk);
    chk(o_conv_end, 1'b1);
  endtask : t_cs
  task automatic t_hs();
    i_high_speed = 1'b1;
    host.read(1'b1);
    code = 12'hc3e;
    host.convert(1'b0);
    wait_end();
    repeat (40) @(negedge i_clk);
    chk(o_data, 12'hc3e);
    chk(o_data_oe, 1'b1);
    code = 12'h3c1;
    i_channel_select = 1'b1;
    host.convert(1'b0);
    chk(o_route_input_two, 1'b1);
    wait_end();
    repeat (40) @(negedge i_clk);
    chk(o_data, 12'h3c1);
    chk(o_done_int_b, 1'b0);
  endtask : t_hs
  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // ****
  // run
  // ****
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {i_rst_b, i_high_speed, i_channel_select, code} = '0;
    {bad_count, total_checks, cycles} = '0;
    repeat (2) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clk);
    chk(o_done_int_b, 1'b1);
    chk(o_track_switch, 1'b1);
    t_fill();
    t_cs();
    t_hs();
    summarize();
  end
endmodule : tb_aci_core
bind aci_core aci_core_chk chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_chip_sel_b(i_chip_sel_b), .i_read_b(i_read_b), .o_conv_end(o_conv_end),
  .o_done_int_b(o_done_int_b), .o_track_switch(o_track_switch),
  .o_route_input_two(o_route_input_two), .o_data_oe(o_data_oe));
`default_nettype wire
